// ---- rtl/tdm_pkg.sv ----
// tdm_pkg: register map, field positions and reset values of the thermal dac code mapper
// assumes an ahb-lite slave with 32-bit data, one register per aligned word
package tdm_pkg;

    // ------------------------------------------------------------
    // register indices as printed, byte address is four times these
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_CTRL_CFG3   = 8'h1a;
    localparam logic [7:0] IDX_DAC_CFG     = 8'h1b;
    localparam logic [7:0] IDX_LOAD_CFG    = 8'h1c;
    localparam logic [7:0] IDX_INT_OFFSET  = 8'h21;
    localparam logic [7:0] IDX_EXT_OFFSET  = 8'h22;
    localparam logic [7:0] IDX_TEMP_IN     = 8'h30;
    localparam logic [7:0] IDX_DAC_STATUS  = 8'h31;
    localparam logic [7:0] IDX_DAC_CODES   = 8'h32;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int THERMAL_SEL_A_BIT = 5;
    localparam int THERMAL_SEL_B_BIT = 6;
    localparam int SPAN_DOUBLE_A_BIT = 0;
    localparam int SPAN_DOUBLE_B_BIT = 1;
    localparam int REF_SEL_BIT       = 4;
    localparam int OFFSET_SIGN_BIT   = 7;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_CFG3_RST  = 8'h00;
    localparam logic [7:0] DAC_CFG_RST    = 8'h00;
    localparam logic [7:0] LOAD_CFG_RST   = 8'h00;
    localparam logic [7:0] OFFSET_RST     = 8'hd8;
    localparam logic [7:0] CODE_FULL      = 8'hff;
    localparam logic [7:0] CODE_ZERO      = 8'h00;
    localparam logic [7:0] OFFSET_NEG_ADD = 8'h80;

    typedef enum logic [1:0] {
        TDM_HTRANS_IDLE   = 2'b00,
        TDM_HTRANS_BUSY   = 2'b01,
        TDM_HTRANS_NONSEQ = 2'b10,
        TDM_HTRANS_SEQ    = 2'b11
    } tdm_htrans_t;

endpackage

// ---- rtl/tdm_code_calc.sv ----
// tdm_code_calc: maps a whole-degree temperature and a zero-code offset to an 8-bit dac code
// assumes both inputs are stable on the same clock; pure combinational
`timescale 1ns/10ps
module tdm_code_calc
    import tdm_pkg::*;
(
    input  wire logic [7:0] tempDeg,
    input  wire logic [7:0] offsetReg,
    output logic      [7:0] dacCode
);
    // offset register holds (t + 128) with bit 7 set for negative, i.e. plain two's complement
    wire logic signed [9:0] tempS   = {{2{tempDeg[7]}}, tempDeg};
    wire logic signed [9:0] offS    = {{2{offsetReg[OFFSET_SIGN_BIT]}}, offsetReg}; // R11
    wire logic signed [9:0] diff    = tempS - offS; // R9
    wire logic              isNeg   = diff[9];
    wire logic              isOver  = ~diff[9] & diff[8];

    // one degree per lsb, clamp both ends instead of wrapping
    assign dacCode = isNeg  ? CODE_ZERO :  // R13
                     isOver ? CODE_FULL :  // R10
                     diff[7:0];            // R5
endmodule

// ---- rtl/tdm_thermal_dac_mapper.sv ----
// tdm_thermal_dac_mapper: register file and thermal code path for a quad 8-bit dac
// assumes ahb-lite single word transfers and same-clock temperature result strobes
//
// Overview of operation
// R1: load-strobe config bit selects dac reference; external reference after reset.
// R2: dac config low four bits give per-channel gain, 0 unity, 1 double.
// R3: two config bits enable thermal mode for channel a and channel b.
// R4: in thermal mode the channel updates on every new sensor result.
// R5: thermal code is 8 bits, one degree per lsb.
// R6: dac config bit 0 doubles span of a, bit 1 of b.
// R7: per-channel 8-bit two's complement zero-code offset; channel a at 21h.
// R8: offset resets to d8h, minus forty degrees.
// R9: thermal code equals temperature minus zero-code offset.
// R10: code saturates at full scale when difference exceeds range.
// R11: negative offsets are t plus 128 with bit 7 set.
// R12: thermal select bits live in control config 3 at 1ah.
// R13: code clamps to zero below the zero-code temperature.
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/10ps
module tdm_thermal_dac_mapper
    import tdm_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [7:0]  intTemp,
    input  wire logic        intTempValid,
    input  wire logic [7:0]  extTemp,
    input  wire logic        extTempValid,
    output logic      [7:0]  dacCodeA,
    output logic      [7:0]  dacCodeB,
    output logic      [3:0]  dacGainDouble,
    output logic             dacRefInternal,
    output logic             thermalUpdA,
    output logic             thermalUpdB
);

    // ------------------------------------------------------------
    // address phase capture
    // ------------------------------------------------------------
    logic [7:0] wIdx_reg;
    logic       wPend_reg;
    logic [7:0] ctrlCfg3_reg;
    logic [7:0] dacCfg_reg;
    logic [7:0] loadCfg_reg;
    logic [7:0] intOffset_reg;
    logic [7:0] extOffset_reg;
    logic [7:0] intTempLast_reg;
    logic [7:0] extTempLast_reg;
    logic [7:0] dacCodeA_reg;
    logic [7:0] dacCodeB_reg;
    logic [31:0] hrdata_reg;
    logic       updA_reg;
    logic       updB_reg;
    logic       hreadyout_reg;
    logic       hresp_reg;

    // only whole-word transfers reach the registers; narrower ones read nothing and write nothing
    wire logic       wordXfer  = (hsize == 3'h2);
    wire logic       addrValid = hsel & hready & htrans[1] & wordXfer;
    wire logic       isWrite   = addrValid & hwrite;
    wire logic       isRead    = addrValid & ~hwrite;
    wire logic [7:0] aIdx      = haddr[9:2];
    wire logic       upperZero = (haddr[31:10] == 22'h000000);

    // ------------------------------------------------------------
    // read decode
    // ------------------------------------------------------------
    wire logic [7:0] codeCalcA;
    wire logic [7:0] codeCalcB;
    logic [31:0] rdNext;

    always_comb begin
        rdNext = 32'h00000000;
        if (!upperZero) begin
            rdNext = 32'h00000000;
        end else if (aIdx == IDX_CTRL_CFG3) begin
            rdNext = {24'h000000, ctrlCfg3_reg};
        end else if (aIdx == IDX_DAC_CFG) begin
            rdNext = {24'h000000, dacCfg_reg};
        end else if (aIdx == IDX_LOAD_CFG) begin
            rdNext = {24'h000000, loadCfg_reg};
        end else if (aIdx == IDX_INT_OFFSET) begin
            rdNext = {24'h000000, intOffset_reg};
        end else if (aIdx == IDX_EXT_OFFSET) begin
            rdNext = {24'h000000, extOffset_reg};
        end else if (aIdx == IDX_TEMP_IN) begin
            rdNext = {16'h0000, extTempLast_reg, intTempLast_reg};
        end else if (aIdx == IDX_DAC_STATUS) begin
            rdNext = {24'h000000, 6'h00, ctrlCfg3_reg[THERMAL_SEL_B_BIT], ctrlCfg3_reg[THERMAL_SEL_A_BIT]};
        end else if (aIdx == IDX_DAC_CODES) begin
            rdNext = {16'h0000, dacCodeB_reg, dacCodeA_reg};
        end
    end

    // zero wait states; unmapped addresses read zero and ignore writes
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wPend_reg <= 1'b0;
            wIdx_reg  <= 8'h00;
        end else begin
            wPend_reg <= isWrite & upperZero;
            wIdx_reg  <= aIdx;
        end
    end

    // read data launched at the address edge, held until the next read
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hrdata_reg <= 32'h00000000;
        end else if (isRead) begin
            hrdata_reg <= rdNext;
        end
    end

    // registered so every bus output leaves a flip-flop; the slave never stalls or errors
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hreadyout_reg <= 1'b1;
            hresp_reg     <= 1'b0;
        end else begin
            hreadyout_reg <= 1'b1;
            hresp_reg     <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    wire logic wrCtrl = wPend_reg & (wIdx_reg == IDX_CTRL_CFG3);
    wire logic wrDac  = wPend_reg & (wIdx_reg == IDX_DAC_CFG);
    wire logic wrLoad = wPend_reg & (wIdx_reg == IDX_LOAD_CFG);
    wire logic wrIOff = wPend_reg & (wIdx_reg == IDX_INT_OFFSET);
    wire logic wrEOff = wPend_reg & (wIdx_reg == IDX_EXT_OFFSET);

    // one register per block; each holds until a word write lands in its data phase
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrlCfg3_reg <= CTRL_CFG3_RST;
        end else if (wrCtrl) begin
            ctrlCfg3_reg <= hwdata[7:0]; // R12
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dacCfg_reg <= DAC_CFG_RST;
        end else if (wrDac) begin
            dacCfg_reg <= hwdata[7:0]; // R2
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            loadCfg_reg <= LOAD_CFG_RST; // R1
        end else if (wrLoad) begin
            loadCfg_reg <= hwdata[7:0]; // R1
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            intOffset_reg <= OFFSET_RST; // R8
        end else if (wrIOff) begin
            intOffset_reg <= hwdata[7:0]; // R7
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            extOffset_reg <= OFFSET_RST; // R8
        end else if (wrEOff) begin
            extOffset_reg <= hwdata[7:0]; // R7
        end
    end

    // ------------------------------------------------------------
    // thermal code path
    // ------------------------------------------------------------
    wire logic selA = ctrlCfg3_reg[THERMAL_SEL_A_BIT]; // R3
    wire logic selB = ctrlCfg3_reg[THERMAL_SEL_B_BIT]; // R3

    // channel 0 is a (on-chip sensor), channel 1 is b (remote sensor)
    wire logic [7:0] chTemp   [2];
    wire logic [7:0] chOffset [2];
    wire logic [7:0] chCode   [2];

    assign chTemp[0]   = intTemp;
    assign chTemp[1]   = extTemp;
    assign chOffset[0] = intOffset_reg;
    assign chOffset[1] = extOffset_reg;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_chan
            tdm_code_calc uCalc (
                .tempDeg   (chTemp[ch]),
                .offsetReg (chOffset[ch]),
                .dacCode   (chCode[ch])
            );
        end
    endgenerate

    assign codeCalcA = chCode[0];
    assign codeCalcB = chCode[1];

    wire logic loadA = selA & intTempValid; // R4
    wire logic loadB = selB & extTempValid; // R4

    // outside thermal mode the codes hold; normal strobed loading is another block's job
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dacCodeA_reg <= CODE_ZERO;
            dacCodeB_reg <= CODE_ZERO;
        end else begin
            if (loadA) dacCodeA_reg <= codeCalcA; // R9
            if (loadB) dacCodeB_reg <= codeCalcB; // R9
        end
    end

    // last results are kept whatever the mode, so software can read them back
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            intTempLast_reg <= CODE_ZERO;
            extTempLast_reg <= CODE_ZERO;
        end else begin
            if (intTempValid) intTempLast_reg <= intTemp;
            if (extTempValid) extTempLast_reg <= extTemp;
        end
    end

    // one-cycle marker that a code was loaded
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            updA_reg <= 1'b0;
            updB_reg <= 1'b0;
        end else begin
            updA_reg <= loadA; // R4
            updB_reg <= loadB; // R4
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // gain bits double as thermal span control for a and b
    assign dacGainDouble  = dacCfg_reg[3:0];                  // R2 R6
    assign dacRefInternal = loadCfg_reg[REF_SEL_BIT];         // R1
    assign dacCodeA       = dacCodeA_reg;
    assign dacCodeB       = dacCodeB_reg;
    assign thermalUpdA    = updA_reg;
    assign thermalUpdB    = updB_reg;
    assign hrdata         = hrdata_reg;
    assign hreadyout      = hreadyout_reg;
    assign hresp          = hresp_reg;
endmodule

// ---- tb/tdm_mapper_assertions.sv ----
// tdm_mapper_assertions: port checks for the thermal dac code mapper
// assumes one clock domain and an asynchronous active-low reset
`timescale 1ns/10ps
module tdm_mapper_assertions (
    input wire logic       clk,
    input wire logic       arst_n,
    input wire logic       hreadyout,
    input wire logic       hresp,
    input wire logic       intTempValid,
    input wire logic       extTempValid,
    input wire logic [7:0] dacCodeA,
    input wire logic [7:0] dacCodeB,
    input wire logic [3:0] dacGainDouble,
    input wire logic       dacRefInternal,
    input wire logic       thermalUpdA,
    input wire logic       thermalUpdB
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence s_load_a; intTempValid ##1 thermalUpdA; endsequence
    a_bus_okay: assert property (hreadyout && !hresp) else $error("bus stalled or errored");
    a_reset_vals: assert property ($rose(arst_n) |-> !dacRefInternal && dacGainDouble == 4'h0)
        else $error("config not at reset value");
    a_upd_a_cause: assert property (thermalUpdA |-> $past(intTempValid)) else $error("a load without result");
    a_upd_b_cause: assert property (thermalUpdB |-> $past(extTempValid)) else $error("b load without result");
    a_upd_a_idle: assert property (!intTempValid |=> !thermalUpdA) else $error("a load pulse too long");
    a_upd_b_idle: assert property (!extTempValid |=> !thermalUpdB) else $error("b load pulse too long");
    a_code_a_hold: assert property (!thermalUpdA |-> $stable(dacCodeA)) else $error("a code moved");
    a_code_b_hold: assert property (!thermalUpdB |-> $stable(dacCodeB)) else $error("b code moved");
    c_load_a: cover property (s_load_a);
endmodule
bind tdm_thermal_dac_mapper tdm_mapper_assertions u_chk (
    .clk(clk), .arst_n(arst_n), .hreadyout(hreadyout), .hresp(hresp), .intTempValid(intTempValid),
    .extTempValid(extTempValid), .dacCodeA(dacCodeA), .dacCodeB(dacCodeB), .dacGainDouble(dacGainDouble),
    .dacRefInternal(dacRefInternal), .thermalUpdA(thermalUpdA), .thermalUpdB(thermalUpdB));

// ---- tb/tb_thermal_dac_code_mapper.sv ----
// tb_thermal_dac_code_mapper: self-checking bench, ahb-lite master plus sensor result pulses
// assumes a zero-wait slave and one-cycle result strobes
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; $display("BAD %0t %h not %h", $time, a, b); end end
module tb_thermal_dac_code_mapper;
    import tdm_pkg::*;
    logic        clk = 1'h0, arst_n = 1'h0, hsel = 1'h0, hwrite = 1'h0, intTempValid = 1'h0, extTempValid = 1'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, g;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [7:0]  intTemp = 8'h0, extTemp = 8'h0, dacCodeA, dacCodeB;
    logic [15:0] pa, pb;
    logic [3:0]  dacGainDouble;
    logic        dacRefInternal, thermalUpdA, thermalUpdB, hreadyout, hresp;
    int          failures = 0, num_checks = 0, seed = 32'h7a01f3a9;
    // corners: offset in high byte, temperature in low byte
    logic [15:0] corner [6] = '{16'hd87f, 16'h807f, 16'h7f80, 16'h0a0a, 16'h0a0b, 16'h0081};

    always #25 clk = ~clk;

    tdm_thermal_dac_mapper DUT (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .intTemp(intTemp), .intTempValid(intTempValid),
        .extTemp(extTemp), .extTempValid(extTempValid), .dacCodeA(dacCodeA), .dacCodeB(dacCodeB),
        .dacGainDouble(dacGainDouble), .dacRefInternal(dacRefInternal), .thermalUpdA(thermalUpdA),
        .thermalUpdB(thermalUpdB));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] expCode(input logic [7:0] t, input logic [7:0] o);
        int d;
        d = $signed(t) - $signed(o);
        return (d < 0) ? 8'h00 : (d > 255) ? 8'hff : d[7:0];
    endfunction

    task automatic finish_test;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic waitReady;
        int n;
        n = 0;
        do begin @(posedge clk); n++; end while (hreadyout !== 1'h1 && n < 20);
        if (n >= 20) begin failures++; finish_test(); end
    endtask

    // zero-extended byte write or read of one register word, result in rd
    task automatic ahb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        hsel <= 1'h1;
        htrans <= TDM_HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= {22'h0, idx, 2'h0};
        waitReady();
        hsel <= 1'h0;
        htrans <= TDM_HTRANS_IDLE;
        hwdata <= {24'h0, wd};
        waitReady();
        rd = hrdata;
    endtask

    task automatic rdChk(input logic [7:0] idx, input logic [31:0] exp);
        ahb(1'h0, idx, 8'h00);
        `CHK(rd, exp)
    endtask

    // one result on each sensor; ua and ub say which channel must show a load marker
    task automatic pulse(input logic [7:0] a, input logic [7:0] b, input logic ua, input logic ub);
        intTemp <= a;
        extTemp <= b;
        intTempValid <= 1'h1;
        extTempValid <= 1'h1;
        @(posedge clk);
        intTempValid <= 1'h0;
        extTempValid <= 1'h0;
        @(negedge clk);
        `CHK(thermalUpdA, ua)
        `CHK(thermalUpdB, ub)
        @(posedge clk);
        @(negedge clk);
        `CHK({thermalUpdA, thermalUpdB}, 2'h0)
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        arst_n <= 1'h1;
        @(posedge clk);
        rdChk(IDX_DAC_CFG, {24'h0, DAC_CFG_RST});
        rdChk(IDX_LOAD_CFG, {24'h0, LOAD_CFG_RST});
        rdChk(IDX_INT_OFFSET, {24'h0, OFFSET_RST});
        rdChk(IDX_EXT_OFFSET, {24'h0, OFFSET_RST});
        rdChk(8'h3f, 32'h0);
        ahb(1'h1, IDX_LOAD_CFG, 8'h10);
        @(negedge clk);
        `CHK(dacRefInternal, 1'h1)
        @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            g = $random(seed);
            ahb(1'h1, IDX_DAC_CFG, {4'h0, g[3:0]});
            @(negedge clk);
            `CHK(dacGainDouble, g[3:0])
            @(posedge clk);
        end
        // a byte-sized transfer must not touch the word registers
        hsize <= 3'h0;
        ahb(1'h1, IDX_DAC_CFG, {4'h0, ~g[3:0]});
        hsize <= 3'h2;
        @(negedge clk);
        `CHK(dacGainDouble, g[3:0])
        @(posedge clk);
        // thermal mode on both channels; random pairs after the corner table
        ahb(1'h1, IDX_CTRL_CFG3, 8'h60);
        for (int i = 0; i < 30; i++) begin
            pa = (i < 6) ? corner[i] : 16'($random(seed));
            pb = 16'($random(seed));
            ahb(1'h1, IDX_INT_OFFSET, pa[15:8]);
            ahb(1'h1, IDX_EXT_OFFSET, pb[15:8]);
            pulse(pa[7:0], pb[7:0], 1'h1, 1'h1);
            `CHK(dacCodeA, expCode(pa[7:0], pa[15:8]))
            `CHK(dacCodeB, expCode(pb[7:0], pb[15:8]))
            @(posedge clk);
        end
        rdChk(IDX_DAC_CODES, {16'h0, expCode(pb[7:0], pb[15:8]), expCode(pa[7:0], pa[15:8])});
        rdChk(IDX_TEMP_IN, {16'h0, pb[7:0], pa[7:0]});
        rdChk(IDX_DAC_STATUS, 32'h3);
        // channel a alone: b must keep its last code
        ahb(1'h1, IDX_CTRL_CFG3, 8'h20);
        pulse(8'h30, 8'h31, 1'h1, 1'h0);
        `CHK(dacCodeA, expCode(8'h30, pa[15:8]))
        `CHK(dacCodeB, expCode(pb[7:0], pb[15:8]))
        @(posedge clk);
        // selects off: results must not reach the codes
        ahb(1'h1, IDX_CTRL_CFG3, 8'h00);
        pulse(8'h11, 8'h22, 1'h0, 1'h0);
        `CHK(dacCodeA, expCode(8'h30, pa[15:8]))
        `CHK(dacCodeB, expCode(pb[7:0], pb[15:8]))
        finish_test();
    end
endmodule
